// file: logic/tcs_sequencer.sv
// Conversion sequencer and standby control for a two-channel sensor
`timescale 1ns/100ps
`default_nettype none
module tcs_sequencer #(
   parameter int INTEG_CYCLES   = tcs_pkg::INTEG_CYCLES,
   parameter int SLOWEST_PERIOD = tcs_pkg::SLOWEST_PERIOD
) (
   input  wire logic        i_clk_sys,
   input  wire logic        i_rst,
   input  wire logic [3:0]  i_addr,
   input  wire logic [7:0]  i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   output logic      [7:0]  o_rdata,
   input  wire logic        i_standby_pin_n,
   input  wire logic [10:0] i_adc_data,
   output logic             o_adc_sel_remote,
   output logic             o_adc_enable,
   output logic             o_sensor_pnp,
   output logic             o_overtemp_alarm_first_n,
   output logic             o_overtemp_alarm_second_n
);
   // A period shorter than a full extended sequence would never leave time to idle
   if (INTEG_CYCLES < 2 || SLOWEST_PERIOD < 4 * INTEG_CYCLES)
   begin : g_bad_timing
      $error("tcs_sequencer: bad timing parameters");
   end

   typedef enum {TCS_IDLE, TCS_LOCAL, TCS_REMOTE} tcs_state_e;

   localparam int CW = $clog2(SLOWEST_PERIOD + 1);

   tcs_pkg::tcs_bus_s    bus;
   tcs_pkg::tcs_result_s result_reg;
   tcs_state_e           state_reg;
   logic [7:0]           config_reg;
   logic [3:0]           rate_reg;
   logic [7:0]           limit1_reg;
   logic [7:0]           limit2_reg;
   logic [CW-1:0]        period_cnt_reg;
   logic [CW-1:0]        phase_cnt_reg;
   logic [10:0]          local_tmp_reg;
   logic                 one_shot_reg;
   logic                 shot_mode_reg;
   logic                 sw_standby;
   logic                 hw_standby;
   logic                 standby;
   logic                 one_shot_req;
   logic                 period_done;
   logic                 start;
   logic                 extended;
   logic [CW-1:0]        phase_len;
   logic                 phase_last;

   assign bus = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

   // Rate code n gives period of SLOWEST_PERIOD >> n
   function automatic logic [CW-1:0] rate_period(input logic [3:0] code);
      logic [CW-1:0] p;
      p = CW'(SLOWEST_PERIOD);
      return p >> code;
   endfunction

   // Scale an 8-bit limit onto the 11-bit result grid
   function automatic logic [10:0] limit_ext(input logic [7:0] lim);
      return {lim, 3'b000};
   endfunction

   // Legacy rates drop the fraction bits
   function automatic logic [10:0] to_grid(input logic [10:0] raw, input logic ext);
      return ext ? raw : {raw[10:3], 3'b000};
   endfunction

   // ==========================================================
   // Standby and request decode
   assign sw_standby   = config_reg[tcs_pkg::CFG_STANDBY_BIT];
   assign hw_standby   = !i_standby_pin_n;
   assign standby      = sw_standby || hw_standby;
   // one-shot only honoured outside hardware standby
   assign one_shot_req = bus.wr && bus.addr == tcs_pkg::ADDR_COMMAND
                         && bus.wdata == tcs_pkg::CMD_ONE_SHOT && !hw_standby;
   assign extended     = shot_mode_reg || rate_reg <= tcs_pkg::RATE_EXT_MAX;
   // Extended mode doubles integration time
   assign phase_len    = extended ? CW'(2 * INTEG_CYCLES) : CW'(INTEG_CYCLES);
   // At or past the end, so a rate change mid-phase cannot run the count away
   assign phase_last   = phase_cnt_reg >= phase_len - CW'(1);
   assign period_done  = period_cnt_reg == '0;
   // A one-shot latched just before the pin fell must not start either
   assign start        = state_reg == TCS_IDLE && !hw_standby
                         && ((!sw_standby && period_done) || one_shot_reg);

   // ==========================================================
   // Registers written by software
   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst)
      begin
         config_reg <= tcs_pkg::CONFIG_RESET;
         rate_reg   <= tcs_pkg::RATE_RESET;
         limit1_reg <= tcs_pkg::LIMIT_RESET;
         limit2_reg <= tcs_pkg::LIMIT_RESET;
      end
      else if (bus.wr)
      begin
         case (bus.addr)
            tcs_pkg::ADDR_CONFIG: config_reg <= bus.wdata;
            tcs_pkg::ADDR_RATE:
               if (bus.wdata[3:0] <= tcs_pkg::RATE_MAX)
                  rate_reg <= bus.wdata[3:0];
            tcs_pkg::ADDR_LIM1:   limit1_reg <= bus.wdata;
            tcs_pkg::ADDR_LIM2:   limit2_reg <= bus.wdata;
            default: ;
         endcase
      end
   end

   // ==========================================================
   // One-shot request latch; set wins over consumption
   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst)
         one_shot_reg <= 1'b0;
      else if (one_shot_req)
         one_shot_reg <= 1'b1;
      else if (hw_standby || state_reg == TCS_IDLE)
         one_shot_reg <= 1'b0;
   end

   // ==========================================================
   // Rate timer, counts from each sequence start
   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst)
         period_cnt_reg <= '0;
      else if (start)
         period_cnt_reg <= rate_period(rate_reg) - CW'(1);
      else if (!period_done)
         period_cnt_reg <= period_cnt_reg - CW'(1);
   end

   // ==========================================================
   // Sequence state machine
   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst)
      begin
         state_reg     <= TCS_IDLE;
         phase_cnt_reg <= '0;
         shot_mode_reg <= 1'b0;
      end
      else if (state_reg != TCS_IDLE && (hw_standby
               || (sw_standby && !shot_mode_reg)))
      begin
         state_reg <= TCS_IDLE;
         shot_mode_reg <= 1'b0;
      end
      else
      begin
         case (state_reg)
            TCS_IDLE:
               if (start)
               begin
                  state_reg     <= TCS_LOCAL;
                  shot_mode_reg <= one_shot_reg;
                  phase_cnt_reg <= '0;
               end
            TCS_LOCAL:
               if (phase_last)
               begin
                  state_reg     <= TCS_REMOTE;
                  phase_cnt_reg <= '0;
               end
               else
                  phase_cnt_reg <= phase_cnt_reg + CW'(1);
            TCS_REMOTE:
               if (phase_last)
               begin
                  state_reg     <= TCS_IDLE;
                  shot_mode_reg <= 1'b0;
               end
               else
                  phase_cnt_reg <= phase_cnt_reg + CW'(1);
            default: state_reg <= TCS_IDLE;
         endcase
      end
   end

   // ==========================================================
   // Results: published together at the end of the sequence
   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst)
      begin
         local_tmp_reg <= '0;
         result_reg    <= '0;
      end
      else if (!hw_standby && (!sw_standby || shot_mode_reg)
               && phase_last)
      begin
         if (state_reg == TCS_LOCAL)
            local_tmp_reg <= to_grid(i_adc_data, extended);
         else if (state_reg == TCS_REMOTE)
         begin
            result_reg.local_t  <= local_tmp_reg;
            result_reg.remote_t <= to_grid(i_adc_data, extended);
         end
      end
   end

   // ==========================================================
   // Converter controls and alarms
   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst)
      begin
         o_adc_enable              <= 1'b0;
         o_adc_sel_remote          <= 1'b0;
         o_sensor_pnp              <= 1'b0;
         o_overtemp_alarm_first_n  <= 1'b1;
         o_overtemp_alarm_second_n <= 1'b1;
      end
      else
      begin
         o_adc_enable     <= state_reg != TCS_IDLE;
         o_adc_sel_remote <= state_reg == TCS_REMOTE;
         o_sensor_pnp     <= config_reg[tcs_pkg::CFG_SENSOR_BIT];
         o_overtemp_alarm_first_n  <= !($signed(result_reg.remote_t)
                                        > $signed(limit_ext(limit1_reg)));
         o_overtemp_alarm_second_n <= !($signed(result_reg.remote_t)
                                        > $signed(limit_ext(limit2_reg)));
      end
   end

   // ==========================================================
   // Read port, data one cycle after the strobe
   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst)
         o_rdata <= '0;
      else if (bus.rd)
      begin
         case (bus.addr)
            tcs_pkg::ADDR_CONFIG:   o_rdata <= config_reg;
            tcs_pkg::ADDR_RATE:     o_rdata <= {4'h0, rate_reg};
            tcs_pkg::ADDR_STATUS:   o_rdata <= {state_reg != TCS_IDLE, 7'h00};
            tcs_pkg::ADDR_LOCAL:    o_rdata <= result_reg.local_t[10:3];
            tcs_pkg::ADDR_REMOTE:   o_rdata <= result_reg.remote_t[10:3];
            tcs_pkg::ADDR_LOCAL_X:  o_rdata <= {result_reg.local_t[2:0], 5'h00};
            tcs_pkg::ADDR_REMOTE_X: o_rdata <= {result_reg.remote_t[2:0], 5'h00};
            tcs_pkg::ADDR_LIM1:     o_rdata <= limit1_reg;
            tcs_pkg::ADDR_LIM2:     o_rdata <= limit2_reg;
            default:                o_rdata <= 8'h00;
         endcase
      end
      else
         o_rdata <= 8'h00;
   end

   // ==========================================================
   // Checks
   sequence s_hw_standby_hit;
      state_reg != TCS_IDLE && hw_standby;
   endsequence

   property p_abort;
      @(posedge i_clk_sys) disable iff (i_rst)
      s_hw_standby_hit |=> state_reg == TCS_IDLE && $stable(result_reg);
   endproperty
   a_abort: assert property (p_abort) else $error("abort failed");

   property p_free_run;
      @(posedge i_clk_sys) disable iff (i_rst)
      state_reg == TCS_IDLE && !standby && period_done |=> state_reg == TCS_LOCAL;
   endproperty
   a_free_run: assert property (p_free_run) else $error("no free-run start");

   property p_hw_no_shot;
      @(posedge i_clk_sys) disable iff (i_rst)
      hw_standby && state_reg == TCS_IDLE |=> state_reg == TCS_IDLE;
   endproperty
   a_hw_no_shot: assert property (p_hw_no_shot) else $error("ran in hw standby");

   property p_sw_idle;
      @(posedge i_clk_sys) disable iff (i_rst)
      sw_standby && !one_shot_reg && state_reg == TCS_IDLE |=> state_reg == TCS_IDLE;
   endproperty
   a_sw_idle: assert property (p_sw_idle) else $error("ran in sw standby");

   property p_hold_busy;
      @(posedge i_clk_sys) disable iff (i_rst)
      state_reg == TCS_LOCAL |=> $stable(result_reg);
   endproperty
   a_hold_busy: assert property (p_hold_busy) else $error("result changed early");

   property p_busy_read;
      @(posedge i_clk_sys) disable iff (i_rst)
      bus.rd && bus.addr == tcs_pkg::ADDR_STATUS
      |=> o_rdata[tcs_pkg::STAT_BUSY_BIT] == ($past(state_reg) != TCS_IDLE);
   endproperty
   a_busy_read: assert property (p_busy_read) else $error("busy bit wrong");

   property p_order;
      @(posedge i_clk_sys) disable iff (i_rst)
      state_reg == TCS_LOCAL && !hw_standby && (!sw_standby || shot_mode_reg)
      ##1 state_reg != TCS_LOCAL |-> state_reg == TCS_REMOTE;
   endproperty
   a_order: assert property (p_order) else $error("remote skipped");

   property p_legacy;
      @(posedge i_clk_sys) disable iff (i_rst)
      rate_reg > tcs_pkg::RATE_EXT_MAX && !shot_mode_reg && state_reg == TCS_REMOTE
      |=> result_reg.remote_t[2:0] == 3'b000 || $stable(result_reg);
   endproperty
   a_legacy: assert property (p_legacy) else $error("fraction in legacy");

   sequence s_sw_standby_hit;
      state_reg != TCS_IDLE && sw_standby && !shot_mode_reg;
   endsequence

   property p_sw_abort;
      @(posedge i_clk_sys) disable iff (i_rst)
      s_sw_standby_hit |=> state_reg == TCS_IDLE && $stable(result_reg);
   endproperty
   a_sw_abort: assert property (p_sw_abort) else $error("sw abort failed");

   sequence s_shot_taken;
      one_shot_req ##1 state_reg == TCS_IDLE && !hw_standby;
   endsequence

   property p_shot_start;
      @(posedge i_clk_sys) disable iff (i_rst)
      s_shot_taken |=> state_reg == TCS_LOCAL && shot_mode_reg;
   endproperty
   a_shot_start: assert property (p_shot_start) else $error("one-shot not started");

   property p_hw_drop;
      @(posedge i_clk_sys) disable iff (i_rst)
      hw_standby |=> !one_shot_reg;
   endproperty
   a_hw_drop: assert property (p_hw_drop) else $error("shot kept");

   property p_pub_end;
      @(posedge i_clk_sys) disable iff (i_rst)
      $changed(result_reg) |-> $past(state_reg) == TCS_REMOTE && $past(phase_last);
   endproperty
   a_pub_end: assert property (p_pub_end) else $error("result moved early");

   property p_conv_off;
      @(posedge i_clk_sys) disable iff (i_rst)
      s_hw_standby_hit |-> ##2 !o_adc_enable;
   endproperty
   a_conv_off: assert property (p_conv_off) else $error("converter left on");

   property p_alarm_first;
      @(posedge i_clk_sys) disable iff (i_rst)
      $signed(result_reg.remote_t) > $signed(limit_ext(limit1_reg))
      |=> !o_overtemp_alarm_first_n;
   endproperty
   a_alarm_first: assert property (p_alarm_first) else $error("alarm one missed");
endmodule
`default_nettype wire

// file: include/tcs_pkg.sv
// Package for the temperature conversion sequencer
`default_nettype none
package tcs_pkg;
   // ==========================================================
   // Register map
   localparam logic [3:0] ADDR_CONFIG   = 4'h0;
   localparam logic [3:0] ADDR_RATE     = 4'h1;
   localparam logic [3:0] ADDR_COMMAND  = 4'h2;
   localparam logic [3:0] ADDR_STATUS   = 4'h3;
   localparam logic [3:0] ADDR_LOCAL    = 4'h4;
   localparam logic [3:0] ADDR_REMOTE   = 4'h5;
   localparam logic [3:0] ADDR_LOCAL_X  = 4'h6;
   localparam logic [3:0] ADDR_REMOTE_X = 4'h7;
   localparam logic [3:0] ADDR_LIM1     = 4'h8;
   localparam logic [3:0] ADDR_LIM2     = 4'h9;
   // ==========================================================
   // Fields and values
   localparam int         CFG_SENSOR_BIT  = 5;
   localparam int         CFG_STANDBY_BIT = 6;
   localparam int         STAT_BUSY_BIT   = 7;
   localparam logic [7:0] CMD_ONE_SHOT    = 8'h0F;
   localparam logic [7:0] CONFIG_RESET    = 8'h00;
   localparam logic [3:0] RATE_RESET      = 4'h8;   // 16 Hz
   localparam logic [3:0] RATE_EXT_MAX    = 4'h6;   // 4 Hz
   localparam logic [3:0] RATE_MAX        = 4'h8;
   localparam logic [7:0] LIMIT_RESET     = 8'h7F;
   // ==========================================================
   // Timing
   localparam int CLK_HZ         = 100_000_000;
   localparam int INTEG_MS       = 60;
   localparam int INTEG_CYCLES   = INTEG_MS * (CLK_HZ / 1000);
   localparam int SLOWEST_PERIOD = 16 * CLK_HZ;  // 0.0625 Hz

   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } tcs_bus_s;

   typedef struct packed {
      logic [10:0] local_t;
      logic [10:0] remote_t;
   } tcs_result_s;
endpackage
`default_nettype wire

// file: tb/tcs_adc_model.sv
// Converter front-end model feeding per-channel samples
`timescale 1ns/100ps
`default_nettype none
module tcs_adc_model (
   input  wire logic        i_clk_sys,
   input  wire logic        i_enable,
   input  wire logic        i_sel_remote,
   input  wire logic [10:0] i_local_val,
   input  wire logic [10:0] i_remote_val,
   output logic      [10:0] o_data
);
   logic [10:0] idle_reg = 11'h2AA;
   // ==========================================================
   // Idle output toggles so a stray sample never looks valid
   always @(posedge i_clk_sys)
   begin
      idle_reg <= ~idle_reg;
   end
   always_comb
   begin
      if (i_enable !== 1'b1)
         o_data = idle_reg;
      else if (i_sel_remote)
         o_data = i_remote_val;
      else
         o_data = i_local_val;
   end
endmodule
`default_nettype wire

// file: tb/tcs_sequencer_test.sv
// Self-checking bench for the conversion sequencer
`timescale 1ns/100ps
`default_nettype none
module tcs_sequencer_test;
   localparam int INTEG = 4;
   logic        i_clk_sys = 1'b0;
   logic        i_rst = 1'b1;
   logic [3:0]  i_addr = 4'h0;
   logic [7:0]  i_wdata = 8'h00;
   logic        i_wr = 1'b0;
   logic        i_rd = 1'b0;
   logic        i_standby_pin_n = 1'b1;
   logic [10:0] adc_data;
   logic [10:0] loc_val = 11'h0C8;
   logic [10:0] rem_val = 11'h088;
   logic [7:0]  o_rdata;
   logic        o_adc_sel_remote;
   logic        o_adc_enable;
   logic        o_sensor_pnp;
   logic        alarm1_n;
   logic        alarm2_n;
   logic [7:0]  run_len = 8'h00;
   logic [7:0]  last_run = 8'h00;
   int          cycles = 0;
   int          miscompares = 0;
   int          checks_done = 0;

   always #5 i_clk_sys = ~i_clk_sys;

   tcs_sequencer #(.INTEG_CYCLES(INTEG), .SLOWEST_PERIOD(4096)) dut (
      .i_clk_sys                 (i_clk_sys),
      .i_rst                     (i_rst),
      .i_addr                    (i_addr),
      .i_wdata                   (i_wdata),
      .i_wr                      (i_wr),
      .i_rd                      (i_rd),
      .o_rdata                   (o_rdata),
      .i_standby_pin_n           (i_standby_pin_n),
      .i_adc_data                (adc_data),
      .o_adc_sel_remote          (o_adc_sel_remote),
      .o_adc_enable              (o_adc_enable),
      .o_sensor_pnp              (o_sensor_pnp),
      .o_overtemp_alarm_first_n  (alarm1_n),
      .o_overtemp_alarm_second_n (alarm2_n)
   );

   tcs_adc_model adc (
      .i_clk_sys    (i_clk_sys),
      .i_enable     (o_adc_enable),
      .i_sel_remote (o_adc_sel_remote),
      .i_local_val  (loc_val),
      .i_remote_val (rem_val),
      .o_data       (adc_data)
   );

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // ==========================================================
   // Converter run length and hang guard
   always @(posedge i_clk_sys)
   begin
      cycles <= cycles + 1;
      if (o_adc_enable === 1'b1)
         run_len <= run_len + 8'h01;
      else
      begin
         if (run_len != 8'h00)
            last_run <= run_len;
         run_len <= 8'h00;
      end
      if (cycles == 20000)
      begin
         miscompares++;
         report_and_stop();
      end
   end

   // ==========================================================
   // Register port tasks
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         miscompares++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge i_clk_sys);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_clk_sys);
      i_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge i_clk_sys);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_clk_sys);
      i_rd <= 1'b0;
      #1;
      d = o_rdata;
   endtask
   task automatic chk(input logic [3:0] a, input logic [7:0] exp);
      logic [7:0] d;
      rd(a, d);
      cmp(d, exp);
   endtask
   // Polling is bounded; a busy edge never seen shows as a mismatch
   task automatic wait_busy(input logic want);
      logic [7:0] s;
      int n;
      n = 0;
      s = 8'h00;
      do
      begin
         rd(tcs_pkg::ADDR_STATUS, s);
         n++;
      end while (s[tcs_pkg::STAT_BUSY_BIT] !== want && n < 300);
      cmp({7'h00, s[tcs_pkg::STAT_BUSY_BIT]}, {7'h00, want});
   endtask
   task automatic idle_chk;
      logic [7:0] s;
      repeat (40) @(posedge i_clk_sys);
      rd(tcs_pkg::ADDR_STATUS, s);
      cmp(s & 8'h80, 8'h00);
   endtask

   // ==========================================================
   // Main sequence
   initial
   begin
      repeat (3) @(posedge i_clk_sys);
      i_rst <= 1'b0;
      chk(tcs_pkg::ADDR_CONFIG, 8'h00);
      chk(tcs_pkg::ADDR_RATE, 8'h08);
      chk(tcs_pkg::ADDR_LIM1, 8'h7F);
      chk(4'hF, 8'h00);
      wr(tcs_pkg::ADDR_LIM1, 8'h10);
      wr(tcs_pkg::ADDR_LIM2, 8'h40);
      wait_busy(1'b1);
      wait_busy(1'b0);
      wait_busy(1'b1);
      wait_busy(1'b0);
      chk(tcs_pkg::ADDR_LOCAL, 8'h19);
      chk(tcs_pkg::ADDR_REMOTE, 8'h11);
      cmp(last_run, 8'(2 * INTEG));
      loc_val <= 11'h190;
      wait_busy(1'b1);
      chk(tcs_pkg::ADDR_LOCAL, 8'h19);
      wait_busy(1'b0);
      chk(tcs_pkg::ADDR_LOCAL, 8'h32);
      cmp({6'h00, alarm2_n, alarm1_n}, 8'h02);
      // Software standby with one-shot at extended resolution
      wr(tcs_pkg::ADDR_CONFIG, 8'h60);
      // Pin copy lags the register by one clock
      @(posedge i_clk_sys);
      #1;
      cmp({7'h00, o_sensor_pnp}, 8'h01);
      wr(tcs_pkg::ADDR_RATE, 8'h06);
      wr(tcs_pkg::ADDR_RATE, 8'h09);
      chk(tcs_pkg::ADDR_RATE, 8'h06);
      idle_chk();
      loc_val <= 11'h0CD;
      rem_val <= 11'h0F3;
      wr(tcs_pkg::ADDR_COMMAND, tcs_pkg::CMD_ONE_SHOT);
      wait_busy(1'b1);
      wait_busy(1'b0);
      chk(tcs_pkg::ADDR_LOCAL, 8'h19);
      chk(tcs_pkg::ADDR_LOCAL_X, 8'hA0);
      chk(tcs_pkg::ADDR_REMOTE, 8'h1E);
      chk(tcs_pkg::ADDR_REMOTE_X, 8'h60);
      cmp(last_run, 8'(4 * INTEG));
      idle_chk();
      // Hardware standby ignores one-shot, port stays alive
      loc_val <= 11'h000;
      // Pin falls the cycle after a one-shot is taken; the pin must win
      wr(tcs_pkg::ADDR_COMMAND, tcs_pkg::CMD_ONE_SHOT);
      i_standby_pin_n <= 1'b0;
      wr(tcs_pkg::ADDR_COMMAND, tcs_pkg::CMD_ONE_SHOT);
      idle_chk();
      cmp(last_run, 8'(4 * INTEG));
      cmp({7'h00, o_adc_enable}, 8'h00);
      chk(tcs_pkg::ADDR_LOCAL, 8'h19);
      chk(tcs_pkg::ADDR_LIM2, 8'h40);
      // Abort of running conversions by both standby kinds
      wr(tcs_pkg::ADDR_CONFIG, 8'h00);
      i_standby_pin_n <= 1'b1;
      wait_busy(1'b1);
      i_standby_pin_n <= 1'b0;
      idle_chk();
      chk(tcs_pkg::ADDR_LOCAL, 8'h19);
      i_standby_pin_n <= 1'b1;
      wait_busy(1'b1);
      wr(tcs_pkg::ADDR_CONFIG, 8'h40);
      idle_chk();
      chk(tcs_pkg::ADDR_LOCAL, 8'h19);
      report_and_stop();
   end
endmodule
`default_nettype wire
